// File: verilog/sadc_regs.vh
// Constants for the serial converter control and result port
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// ****************************************
// Clock and timing
// ****************************************
`define SADC_CLK_MHZ 100
// Conversion time in ns, plain default
`define SADC_CONV_NS 2000
`define SADC_CONV_CYC ((`SADC_CONV_NS * `SADC_CLK_MHZ + 999) / 1000)

// ****************************************
// Command byte fields
// ****************************************
`define SADC_CMD_ADDR_HI 7
`define SADC_CMD_ADDR_LO 4
`define SADC_CMD_LEN_HI 3
`define SADC_CMD_LEN_LO 2
`define SADC_CMD_LSBF 1
`define SADC_CMD_BIPOLAR 0

// ****************************************
// Lengths, counts and reset values
// ****************************************
`define SADC_CMD_BITS 4'h8
`define SADC_ADDR_BITS 4'h4
`define SADC_SAMPLE_EDGE 5'h04
`define SADC_LEN_8 2'h1
`define SADC_LEN_16 2'h3
`define SADC_CFG_RST 8'h00
`define SADC_RES_RST 12'h000

`endif

// File: verilog/sadc_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module sadc_sync (
    input wire i_clk,
    input wire i_rst,
    input wire i_pin,
    output reg o_level
);

    reg s1_reg; // Metastability catcher, read only by s2
    reg s2_reg; // Second stage
    reg s3_reg; // Third stage

    // ****************************************
    // Sync chain; change taken once s2 and s3 agree
    // ****************************************
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            o_level <= 1'b1;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                // Stable for two samples
                o_level <= s3_reg;
            end
        end
    end

endmodule // sadc_sync

// File: verilog/sadc_port.v
// Serial control and result port of a 12-bit converter
`timescale 1ns/1ps
`include "sadc_regs.vh"

module sadc_port (
    input wire i_clk,
    input wire i_rst,
    input wire i_cs_n,
    input wire i_sclk,
    input wire i_din,
    input wire [11:0] i_adc_result,
    output reg o_dout,
    output reg o_dout_oe,
    output reg o_eoc,
    output reg [3:0] o_mux_addr,
    output reg o_addr_valid,
    output reg o_sample,
    output reg o_conv_start,
    output reg o_bipolar
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire cs_n_s; // Filtered select level
    wire sclk_s; // Filtered shift clock level
    wire din_s; // Filtered command data level

    sadc_sync u_cs (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_cs_n),
        .o_level(cs_n_s)
    );

    sadc_sync u_sclk (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_sclk),
        .o_level(sclk_s)
    );

    sadc_sync u_din (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_din),
        .o_level(din_s)
    );

    // ****************************************
    // State
    // ****************************************
    reg cs_d_reg; // Previous select level
    reg sclk_d_reg; // Previous shift clock level
    reg active_reg; // Port accepts shift clock and data
    reg [3:0] rise_cnt_reg; // Command rising edges this transfer, up to 8
    reg [4:0] fall_cnt_reg; // Falling edges this transfer
    reg [7:0] cmd_sh_reg; // Command shift register
    reg [7:0] cfg_reg; // Format of the result being sent
    reg [15:0] out_sh_reg; // Outgoing result bits, next at top
    reg [11:0] res_reg; // Last completed conversion
    reg busy_reg; // Conversion engine running
    reg [15:0] conv_cnt_reg; // Conversion time counter

    wire cs_fall = cs_d_reg & ~cs_n_s;
    wire cs_rise = ~cs_d_reg & cs_n_s;
    wire sclk_rise = active_reg & ~sclk_d_reg & sclk_s;
    wire sclk_fall = active_reg & sclk_d_reg & ~sclk_s;
    wire [4:0] fall_next = fall_cnt_reg + 5'h01;
    // Edges are gated by active_reg, so a shift clock
    // that the host toggles while deselected moves nothing.
    // The sync chain reset level of the shift clock is
    // high while the pin idles low; the gate also hides
    // the false edge that this gives just after reset.

    // Transfer length from the format in force
    reg [4:0] xfer_len;
    always @* begin
        case (cfg_reg[`SADC_CMD_LEN_HI:`SADC_CMD_LEN_LO])
            `SADC_LEN_8: xfer_len = 5'h08;
            `SADC_LEN_16: xfer_len = 5'h10;
            default: xfer_len = 5'h0c;
        endcase
    end

    // Result laid out for sending, in chosen bit order.
    // The order is that of the format in force, which is
    // the command of the previous transfer, not this one.
    reg [11:0] res_ord;
    integer k;
    always @* begin
        res_ord = res_reg;
        if (cfg_reg[`SADC_CMD_LSBF]) begin
            for (k = 0; k < 12; k = k + 1) begin
                res_ord[k] = res_reg[11 - k];
            end
        end
    end

    // ****************************************
    // Serial port sequencing
    // ****************************************
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
            active_reg <= 1'b0;
            rise_cnt_reg <= 4'h0;
            fall_cnt_reg <= 5'h00;
            cmd_sh_reg <= `SADC_CFG_RST;
            cfg_reg <= `SADC_CFG_RST;
            out_sh_reg <= 16'h0000;
            o_dout <= 1'b0;
            o_dout_oe <= 1'b0;
            o_mux_addr <= 4'h0;
            o_addr_valid <= 1'b0;
            o_sample <= 1'b0;
            o_bipolar <= 1'b0;
        end else begin
            cs_d_reg <= cs_n_s;
            sclk_d_reg <= sclk_s;
            o_dout_oe <= ~cs_n_s;
            if (cs_fall) begin
                // Fresh transfer: clear counters, open the port
                active_reg <= 1'b1;
                rise_cnt_reg <= 4'h0;
                fall_cnt_reg <= 5'h00;
                o_addr_valid <= 1'b0;
                o_sample <= 1'b0;
                // First bit goes out at once
                o_dout <= res_ord[11];
                out_sh_reg <= {res_ord[10:0], 5'h00};
            end else if (cs_rise) begin
                // Ignore clock and data until next select
                active_reg <= 1'b0;
                o_sample <= 1'b0;
            end else begin
                if (sclk_rise && rise_cnt_reg < `SADC_CMD_BITS) begin
                    // Command bits arrive MSB first
                    cmd_sh_reg <= {cmd_sh_reg[6:0], din_s};
                    rise_cnt_reg <= rise_cnt_reg + 4'h1;
                    if (rise_cnt_reg == `SADC_ADDR_BITS - 4'h1) begin
                        o_mux_addr <= {cmd_sh_reg[2:0], din_s};
                        o_addr_valid <= 1'b1;
                    end
                end
                if (sclk_fall && fall_cnt_reg < xfer_len) begin
                    // Result bits, sample window and format move on shift clock falls
                    fall_cnt_reg <= fall_next;
                    o_dout <= out_sh_reg[15];
                    out_sh_reg <= {out_sh_reg[14:0], 1'b0};
                    if (fall_next == `SADC_SAMPLE_EDGE) begin
                        o_sample <= 1'b1;
                    end
                    if (fall_next == xfer_len) begin
                        // Host clocks exactly the length, so this ends it
                        o_sample <= 1'b0;
                        cfg_reg <= cmd_sh_reg;
                        o_bipolar <= ~cmd_sh_reg[`SADC_CMD_BIPOLAR];
                    end
                end
            end
        end
    end

    // Final fall of a transfer, seen in the same cycle.
    // Kept combinational so that the engine starts on the
    // very edge at which the port closes the sample window.
    // A select edge in that cycle wins and no start is made.
    wire last_fall = sclk_fall & ~cs_fall & ~cs_rise &
        (fall_cnt_reg < xfer_len) & (fall_next == xfer_len);

    // ****************************************
    // Conversion engine, free of host clocks
    // ****************************************
    // Fixed-time stand-in for the successive approximation;
    // the analog core result is taken when the time is up.
    // A new select fall does not abort a running conversion;
    // the host is expected to wait for the end flag, and a
    // transfer made early returns the older result.
    // The counter is wide enough for long conversion times
    // at the cost of a few idle flip-flops.
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            busy_reg <= 1'b0;
            conv_cnt_reg <= 16'h0000;
            res_reg <= `SADC_RES_RST;
            o_eoc <= 1'b1;
            o_conv_start <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            if (last_fall) begin
                busy_reg <= 1'b1;
                conv_cnt_reg <= 16'h0000;
                o_conv_start <= 1'b1;
                o_eoc <= 1'b0;
            end else if (busy_reg) begin
                if (conv_cnt_reg == `SADC_CONV_CYC - 1) begin
                    busy_reg <= 1'b0;
                    res_reg <= i_adc_result;
                    o_eoc <= 1'b1;
                end else begin
                    conv_cnt_reg <= conv_cnt_reg + 16'h0001;
                end
            end
        end
    end

endmodule // sadc_port

// File: test/sadc_port_asserts.sv
// Concurrent checks on the converter port pins
`timescale 1ns/1ps

module sadc_port_asserts (
    input wire i_clk,
    input wire i_rst,
    input wire i_cs_n,
    input wire i_sclk,
    input wire o_dout,
    input wire o_dout_oe,
    input wire o_eoc,
    input wire o_addr_valid,
    input wire o_sample,
    input wire o_conv_start
);
    // ****
    // Pin timing checks
    // ****
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // Select high long enough must float the output
    property p_oe_off;
        i_cs_n [*8] |-> !o_dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("dout driven");
    property p_oe_on;
        (!i_cs_n) [*8] |-> o_dout_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("dout floats");
    // Sync delay allows 3 to 6 cycles after the shift fall
    property p_dout_fall;
        $changed(o_dout) && o_dout_oe && $past(o_dout_oe)
            |-> $past(!i_sclk, 3) && $past(i_sclk, 7);
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("dout moved");
    property p_eoc_fall;
        o_conv_start |-> ##[0:2] !o_eoc;
    endproperty
    a_eoc_fall: assert property (p_eoc_fall) else $error("eoc high");
    property p_eoc_hold;
        $fell(o_eoc) |=> (!o_eoc) throughout (##190 1);
    endproperty
    a_eoc_hold: assert property (p_eoc_hold) else $error("eoc early");
    property p_eoc_rise;
        $fell(o_eoc) |-> ##[195:206] o_eoc;
    endproperty
    a_eoc_rise: assert property (p_eoc_rise) else $error("eoc late");
    // Sampling may only start once the address is known
    property p_samp_on;
        $rose(o_sample) |-> o_addr_valid && !i_cs_n;
    endproperty
    a_samp_on: assert property (p_samp_on) else $error("early sample");
    property p_samp_off;
        $fell(o_sample) |-> ##[0:1] o_conv_start;
    endproperty
    a_samp_off: assert property (p_samp_off) else $error("no start");
endmodule // sadc_port_asserts

bind sadc_port sadc_port_asserts u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
    .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_eoc(o_eoc),
    .o_addr_valid(o_addr_valid), .o_sample(o_sample),
    .o_conv_start(o_conv_start)
);

// File: test/sadc_host.sv
// Host serial master model: select, shift clock, command
`timescale 1ns/1ps

module sadc_host (
    input wire i_clk,
    input wire i_line,
    output reg o_cs_n,
    output reg o_sclk,
    output reg o_din
);
    // Idle: deselected, shift clock parked low
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    // ****
    // One frame of len clocks, 80 ns shift period
    // ****
    task automatic xfer(input [7:0] cmd, input [4:0] len,
        output [15:0] rx);
        integer i;
        begin
            rx = 16'h0000;
            @(posedge i_clk) o_cs_n <= 1'b0;
            repeat (8) @(posedge i_clk);
            for (i = 0; i < len; i = i + 1) begin
                // Command MSB first, then a toggling filler
                o_din <= (i < 8) ? cmd[7 - i] : ~o_din;
                repeat (4) @(posedge i_clk);
                o_sclk <= 1'b1;
                repeat (4) @(posedge i_clk);
                rx = {rx[14:0], i_line};
                o_sclk <= 1'b0;
            end
            repeat (8) @(posedge i_clk);
            o_cs_n <= 1'b1;
            repeat (8) @(posedge i_clk);
        end
    endtask
    // Shift clock toggled while deselected
    task automatic wiggle(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                repeat (4) @(posedge i_clk);
                o_sclk <= 1'b1;
                repeat (4) @(posedge i_clk);
                o_sclk <= 1'b0;
            end
            repeat (8) @(posedge i_clk);
        end
    endtask
endmodule // sadc_host

// File: test/test_sadc_port.sv
// Self-checking bench for the converter serial port
`timescale 1ns/1ps

module test_sadc_port;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [11:0] adc_result = 12'h000;
    reg last_bit = 1'b0;
    reg [15:0] rx;
    wire cs_n, sclk, din, dout, dout_oe, eoc, addr_valid, sample, bipolar;
    wire [3:0] mux_addr;
    wire dline;
    integer num_errors = 0;
    integer checks = 0;
    integer cycles = 0;
    always #5 clk = ~clk;
    // Released line shows the inverse of its last driven bit
    always @(posedge clk) if (dout_oe) last_bit <= dout;
    assign dline = dout_oe ? dout : ~last_bit;
    sadc_port u_sadc_port (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_din(din), .i_adc_result(adc_result),
        .o_dout(dout), .o_dout_oe(dout_oe), .o_eoc(eoc),
        .o_mux_addr(mux_addr), .o_addr_valid(addr_valid),
        .o_sample(sample), .o_conv_start(), .o_bipolar(bipolar));
    sadc_host host (.i_clk(clk), .i_line(dline), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_din(din));
    // ****
    // Helpers
    // ****
    task chk(input [15:0] got, input [15:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // Frame, then wait a bounded time for the conversion end
    task frame(input [7:0] cmd, input [4:0] len, input [11:0] nxt,
        input [15:0] exp);
        integer n;
        begin
            @(posedge clk) adc_result <= nxt;
            host.xfer(cmd, len, rx);
            chk(rx, exp);
            chk({10'h000, mux_addr, addr_valid, bipolar},
                {10'h000, cmd[7:4], 1'b1, ~cmd[0]});
            chk({15'h0000, eoc}, 16'h0000);
            n = 0;
            while (eoc !== 1'b1 && n < 300) begin
                @(posedge clk);
                n = n + 1;
            end
            chk({15'h0000, eoc}, 16'h0001);
        end
    endtask
    // ****
    // Scenarios
    // ****
    task t_idle;
        begin
            chk({14'h0000, dout_oe, eoc}, 16'h0001);
            $display("test idle done");
        end
    endtask
    // First frame returns the reset result, MSB first
    task t_first;
        begin
            frame(8'h51, 5'h0c, 12'ha5c, 16'h0000);
            $display("test first done");
        end
    endtask
    // LSB-first order only applies from the next frame
    task t_cfg_lsb;
        begin
            frame(8'ha2, 5'h0c, 12'h3c1, 16'h0a5c);
            $display("test config done");
        end
    endtask
    // 12'h3c1 sent LSB first reads back as 12'h83c
    task t_lsb_out;
        begin
            frame(8'hf1, 5'h0c, 12'hbd7, 16'h083c);
            $display("test lsb done");
        end
    endtask
    // 16-bit length: zero padded; 8-bit: first byte only
    task t_lengths;
        begin
            frame(8'h0c, 5'h0c, 12'h5a3, 16'h0bd7);
            frame(8'h04, 5'h10, 12'h96e, 16'h5a30);
            frame(8'h0e, 5'h08, 12'h777, 16'h0096);
            $display("test lengths done");
        end
    endtask
    // Reset mid-run clears result and format; clock ignored
    task t_reset;
        begin
            @(posedge clk) rst <= 1'b1;
            repeat (4) @(posedge clk);
            rst <= 1'b0;
            repeat (6) @(posedge clk);
            chk({14'h0000, dout_oe, eoc}, 16'h0001);
            host.wiggle(12);
            chk({15'h0000, eoc}, 16'h0001);
            frame(8'h51, 5'h0c, 12'h123, 16'h0000);
            $display("test reset done");
        end
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_idle;
        t_first;
        t_cfg_lsb;
        t_lsb_out;
        t_lengths;
        t_reset;
        end_sim;
    end
endmodule // test_sadc_port
